// *** design/exec_pkg.sv ***
// Constants for the execution datapath: status word layout, sizes, opcodes.
// Assumes nothing of its surroundings; used by package-qualified names only.
package exec_pkg;

	localparam int DATA_W = 16;
	localparam int REG_COUNT = 24;
	localparam int GP_COUNT = 16;
	localparam int ADDR_W = 5;
	localparam int MAC_W = 24;
	localparam int SLICE_W = 4;
	localparam int ACC_W = 32;
	localparam int MUL_PASSES = 4;

	// Status word, bit 15 is the msb: carry at 15, positive 14, zero 13, negative 12
	localparam int SW_CARRY = 15;
	localparam int SW_POS = 14;
	localparam int SW_ZERO = 13;
	localparam int SW_NEG = 12;
	localparam int SW_RSV_LO = 8;
	localparam int SW_KEY_LO = 4;
	localparam int SW_PAGE_LO = 0;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [31:0] ACC_RESET = 32'h0000_0000;
	localparam logic [2:0] PASS_RESET = 3'h0;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_ADD,
		OP_ADC,
		OP_SUB,
		OP_SBB,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_NOT,
		OP_PASS,
		OP_SHIFT,
		OP_MAC_CLR,
		OP_MAC_STEP,
		OP_LOAD_SW
	} op_t;

	typedef enum logic [1:0] {
		SH_LOGICAL,
		SH_ARITH,
		SH_ROTATE,
		SH_FUNNEL
	} shift_t;

endpackage : exec_pkg

// *** design/barrel_shifter.sv ***
// 32-in, 16-out right shift network, all shift flavours built from one funnel.
// Assumes shift amount and mode come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module barrel_shifter (
	input wire logic [31:0] funnelIn,
	input wire logic [4:0] amount,
	output logic [15:0] result
);
	logic [31:0] shifted;
	always_comb begin
		shifted = funnelIn >> amount;
		result = shifted[15:0];
	end
endmodule : barrel_shifter
`default_nettype wire

// *** design/cpu_execution_datapath.sv ***
// Execution datapath: ALU, 24-word register file, 24x4 MAC, shifter, status word.
// Assumes a microcode sequencer on the same clock issuing one microword per cycle.
//
// Function
// - ALU finishes any one- or two-operand 16-bit operation in one cycle.
// - Two's complement 16, 32, 48 bit fixed and floating formats supported.
// - ALU outcome flags land in the status word condition field.
// - Register file holds twenty-four 16-bit words.
// - Registers 0-15 program visible; 16-23 reachable only by microcode.
// - Consecutive general registers concatenate into wide operands, wrapping 15 to 0.
// - Three read ports and one write port all act in one cycle.
// - MAC multiplies 24-bit by 4-bit slice and accumulates in one cycle.
// - Full 16x16 multiply completes after four MAC passes.
// - Shifter takes 32 bits, yields 16 bits, any right shift, one cycle.
// - All shifts, rotates and normalises use the barrel shifter.
// - Status word holds C, P, Z, N, page-set and privilege-key fields.
// - Condition flags refresh after every logic, shift and arithmetic operation.
// - Page-set field selects page register set in expanded memory accesses.
// - Privilege-key field is the access key during memory protection.
// - Privileged instructions are legal only when privilege-key field is zero.
// - Layout msb-first: flags 0-3, reserved 4-7, key 8-11, page 12-15.
// - Carry on add carry or no subtract borrow; P, Z, N by sign.
`timescale 1ns/100ps
`default_nettype none
module cpu_execution_datapath #(
	parameter int REGS = exec_pkg::REG_COUNT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire exec_pkg::op_t opSel,
	input wire logic [4:0] rdAddrA,
	input wire logic [4:0] rdAddrB,
	input wire logic microMode,
	input wire logic wideRead,
	input wire logic useImm,
	input wire logic [15:0] immData,
	input wire logic wrEn,
	input wire logic [4:0] wrAddr,
	input wire exec_pkg::shift_t shiftMode,
	input wire logic [4:0] shiftAmt,
	input wire logic [1:0] macLoadGroup,
	output logic [15:0] portA,
	output logic [15:0] portB,
	output logic [15:0] portC,
	output logic [15:0] aluResult,
	output logic [15:0] statusWord,
	output logic [3:0] condFlags,
	output logic [3:0] pageSetSelect,
	output logic [3:0] privilegeKey,
	output logic privilegedLegal,
	output logic [31:0] macAcc,
	output logic macDone,
	output logic accessFault
);

	////////////////////////////////////////////////////////////////////
	// Register file

	logic [15:0] regs_ff [REGS];
	logic [4:0] addrA;
	logic [4:0] addrB;
	logic [4:0] addrC;

	// Program accesses see only 0-15 and wrap within that bank
	function automatic logic [4:0] mapAddr(input logic [4:0] a, input logic micro,
		input logic [1:0] step);
		logic [3:0] w;
		w = a[3:0] + {2'h0, step};
		// Microcode may also walk a wide operand through the general bank
		if (micro && a[4])
			mapAddr = (a < 5'(REGS)) ? a : 5'h00;
		else
			mapAddr = {1'b0, w};
	endfunction : mapAddr

	// Unmapped microcode reads return register 0; accessFault is raised for rdAddrA only
	logic illegalAddr;
	always_comb begin
		addrA = mapAddr(rdAddrA, microMode, 2'h0);
		addrB = wideRead ? mapAddr(rdAddrA, microMode, 2'h1) : mapAddr(rdAddrB, microMode, 2'h0);
		addrC = mapAddr(rdAddrA, microMode, 2'h2);
		illegalAddr = microMode ? (rdAddrA >= 5'(REGS)) : 1'b0;
	end

	always_comb begin
		portA = regs_ff[addrA];
		portB = regs_ff[addrB];
		portC = regs_ff[addrC];
	end

	logic [4:0] wrMapped;
	logic wrOk;
	always_comb begin
		wrMapped = microMode ? wrAddr : {1'b0, wrAddr[3:0]};
		wrOk = wrEn && (wrMapped < 5'(REGS));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < REGS; i++)
				regs_ff[i] <= exec_pkg::REG_RESET;
		end else if (wrOk) begin
			regs_ff[wrMapped] <= aluResult;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Shifter

	logic [31:0] funnel;
	logic [15:0] shiftOut;
	always_comb begin
		unique case (shiftMode)
			exec_pkg::SH_LOGICAL: funnel = {16'h0000, portA};
			exec_pkg::SH_ARITH: funnel = {{16{portA[15]}}, portA};
			exec_pkg::SH_ROTATE: funnel = {portA, portA};
			exec_pkg::SH_FUNNEL: funnel = {portA, portB};
		endcase
	end

	barrel_shifter shifterInst (
		.funnelIn(funnel),
		.amount(shiftAmt),
		.result(shiftOut)
	);

	////////////////////////////////////////////////////////////////////
	// ALU

	logic [15:0] statusWord_ff;
	logic [15:0] opB;
	logic [16:0] sum;
	logic carryOut;
	logic flagUpdate;
	logic [15:0] nxt_result;
	always_comb begin
		opB = useImm ? immData : portB;
		sum = 17'h00000;
		carryOut = statusWord_ff[exec_pkg::SW_CARRY];
		flagUpdate = 1'b1;
		nxt_result = portA;
		unique case (opSel)
			exec_pkg::OP_ADD: sum = {1'b0, portA} + {1'b0, opB};
			exec_pkg::OP_ADC: sum = {1'b0, portA} + {1'b0, opB}
				+ {16'h0000, statusWord_ff[exec_pkg::SW_CARRY]};
			// Subtract carry means no borrow, so chained words need no inversion
			exec_pkg::OP_SUB: sum = {1'b0, portA} + {1'b0, ~opB} + 17'h00001;
			exec_pkg::OP_SBB: sum = {1'b0, portA} + {1'b0, ~opB}
				+ {16'h0000, statusWord_ff[exec_pkg::SW_CARRY]};
			default: sum = 17'h00000;
		endcase
		unique case (opSel)
			exec_pkg::OP_ADD, exec_pkg::OP_ADC, exec_pkg::OP_SUB, exec_pkg::OP_SBB: begin
				nxt_result = sum[15:0];
				carryOut = sum[16];
			end
			exec_pkg::OP_AND: nxt_result = portA & opB;
			exec_pkg::OP_OR: nxt_result = portA | opB;
			exec_pkg::OP_XOR: nxt_result = portA ^ opB;
			exec_pkg::OP_NOT: nxt_result = ~portA;
			exec_pkg::OP_SHIFT: nxt_result = shiftOut;
			exec_pkg::OP_PASS: begin
				nxt_result = opB;
				flagUpdate = 1'b0;
			end
			default: begin
				nxt_result = portA;
				flagUpdate = 1'b0;
			end
		endcase
		aluResult = nxt_result;
	end

	////////////////////////////////////////////////////////////////////
	// Status word

	logic [15:0] nxt_status;
	always_comb begin
		nxt_status = statusWord_ff;
		if (opSel == exec_pkg::OP_LOAD_SW) begin
			nxt_status = opB;
			// Reserved bits always read back as zero, whatever microcode loads
			nxt_status[exec_pkg::SW_RSV_LO +: 4] = 4'h0;
		end else if (flagUpdate) begin
			nxt_status[exec_pkg::SW_CARRY] = carryOut;
			nxt_status[exec_pkg::SW_POS] = !nxt_result[15] && (nxt_result != 16'h0000);
			nxt_status[exec_pkg::SW_ZERO] = (nxt_result == 16'h0000);
			nxt_status[exec_pkg::SW_NEG] = nxt_result[15];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			statusWord_ff <= exec_pkg::STATUS_RESET;
		else
			statusWord_ff <= nxt_status;
	end

	always_comb begin
		statusWord = statusWord_ff;
		condFlags = statusWord_ff[exec_pkg::SW_CARRY:exec_pkg::SW_NEG];
		pageSetSelect = statusWord_ff[exec_pkg::SW_PAGE_LO +: 4];
		privilegeKey = statusWord_ff[exec_pkg::SW_KEY_LO +: 4];
		privilegedLegal = (privilegeKey == 4'h0);
	end

	////////////////////////////////////////////////////////////////////
	// Multiplier/accumulator

	logic [31:0] acc_ff;
	logic [2:0] pass_ff;
	logic [23:0] multiplicand;
	logic [3:0] slice;
	logic [27:0] partial;
	logic [31:0] aligned;
	always_comb begin
		multiplicand = {{8{portA[15]}}, portA};
		slice = opB[pass_ff[1:0]*4 +: 4];
		// Sign-extend before multiplying so a negative multiplicand accumulates right
		partial = {{4{multiplicand[23]}}, multiplicand} * {24'h000000, slice};
		aligned = {{4{partial[27]}}, partial} << (pass_ff[1:0] * 4);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_ff <= exec_pkg::ACC_RESET;
			pass_ff <= exec_pkg::PASS_RESET;
		end else if (opSel == exec_pkg::OP_MAC_CLR) begin
			acc_ff <= exec_pkg::ACC_RESET;
			pass_ff <= {1'b0, macLoadGroup};
			// Steps past the last pass are ignored so a stray microword cannot skew the sum
		end else if (opSel == exec_pkg::OP_MAC_STEP && pass_ff < 3'(exec_pkg::MUL_PASSES)) begin
			acc_ff <= acc_ff + aligned;
			pass_ff <= pass_ff + 3'h1;
		end
	end

	always_comb begin
		macAcc = acc_ff;
		macDone = (pass_ff == 3'(exec_pkg::MUL_PASSES));
		accessFault = illegalAddr;
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	chk_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
		flagUpdate |=> statusWord_ff[exec_pkg::SW_ZERO] == ($past(nxt_result) == 16'h0000))
		else $error("zero flag wrong");

	chk_add_carry: assert property (@(posedge clk) disable iff (!rst_n)
		(opSel == exec_pkg::OP_ADD) |=> statusWord_ff[exec_pkg::SW_CARRY]
			== (({1'b0, $past(portA)} + {1'b0, $past(opB)}) > 17'h0ffff))
		else $error("carry flag wrong");

	chk_sign_flags: assert property (@(posedge clk) disable iff (!rst_n)
		flagUpdate |=> !(statusWord_ff[exec_pkg::SW_POS] && statusWord_ff[exec_pkg::SW_NEG]))
		else $error("positive and negative both set");

	chk_priv_legal: assert property (@(posedge clk) disable iff (!rst_n)
		privilegedLegal == (statusWord_ff[7:4] == 4'h0))
		else $error("privilege legality wrong");

	chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		statusWord_ff[11:8] == 4'h0)
		else $error("reserved bits set");

	chk_reg_write: assert property (@(posedge clk) disable iff (!rst_n)
		wrOk |=> regs_ff[$past(wrMapped)] == $past(aluResult))
		else $error("register write lost");

	sequence macStart;
		opSel == exec_pkg::OP_MAC_CLR && macLoadGroup == 2'h0;
	endsequence

	sequence fourSteps;
		(opSel == exec_pkg::OP_MAC_STEP) [*4];
	endsequence

	chk_mac_four: assert property (@(posedge clk) disable iff (!rst_n)
		macStart ##1 fourSteps |=> macDone)
		else $error("multiply not done after four passes");

	chk_mac_step: assert property (@(posedge clk) disable iff (!rst_n)
		(opSel == exec_pkg::OP_MAC_STEP && !macDone) |=> pass_ff == $past(pass_ff) + 3'h1)
		else $error("pass counter stuck");

	chk_done_holds: assert property (@(posedge clk) disable iff (!rst_n)
		(macDone && opSel != exec_pkg::OP_MAC_CLR) |=> macDone)
		else $error("finished multiply lost its done flag");

	chk_sub_carry: assert property (@(posedge clk) disable iff (!rst_n)
		(opSel == exec_pkg::OP_SUB) |=> statusWord_ff[exec_pkg::SW_CARRY]
			== ($past(portA) >= $past(opB)))
		else $error("subtract carry wrong");

	chk_logic_carry: assert property (@(posedge clk) disable iff (!rst_n)
		(opSel inside {exec_pkg::OP_AND, exec_pkg::OP_OR, exec_pkg::OP_XOR, exec_pkg::OP_NOT,
			exec_pkg::OP_SHIFT}) |=> $stable(statusWord_ff[exec_pkg::SW_CARRY]))
		else $error("carry changed by logic or shift");

	chk_neg_flag: assert property (@(posedge clk) disable iff (!rst_n)
		flagUpdate |=> statusWord_ff[exec_pkg::SW_NEG] == $past(nxt_result[15]))
		else $error("negative flag wrong");

	chk_flags_held: assert property (@(posedge clk) disable iff (!rst_n)
		(!flagUpdate && opSel != exec_pkg::OP_LOAD_SW) |=> $stable(statusWord_ff))
		else $error("status changed without an update");

	chk_load_status: assert property (@(posedge clk) disable iff (!rst_n)
		(opSel == exec_pkg::OP_LOAD_SW) |=> statusWord_ff == ($past(opB) & 16'hf0ff))
		else $error("status load wrong");

	chk_shift_result: assert property (@(posedge clk) disable iff (!rst_n)
		(opSel == exec_pkg::OP_SHIFT) |-> aluResult == 16'(funnel >> shiftAmt))
		else $error("shift result wrong");

	chk_prog_bank: assert property (@(posedge clk) disable iff (!rst_n)
		!microMode |-> !addrA[4] && !addrB[4] && !addrC[4])
		else $error("program view left the general bank");

	chk_wide_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		(!microMode && wideRead && rdAddrA[3:0] == 4'hf)
			|-> addrB == 5'h00 && addrC == 5'h01)
		else $error("wide operand did not wrap");

	sequence macClear;
		opSel == exec_pkg::OP_MAC_CLR;
	endsequence

	sequence macIdle;
		opSel != exec_pkg::OP_MAC_CLR && opSel != exec_pkg::OP_MAC_STEP;
	endsequence

	chk_mac_clear: assert property (@(posedge clk) disable iff (!rst_n)
		macClear |=> acc_ff == exec_pkg::ACC_RESET
			&& pass_ff == {1'b0, $past(macLoadGroup)})
		else $error("accumulator not cleared");

	chk_acc_hold: assert property (@(posedge clk) disable iff (!rst_n)
		macIdle |=> $stable(acc_ff) && $stable(pass_ff))
		else $error("accumulator moved without a step");

endmodule : cpu_execution_datapath
`default_nettype wire

// *** testbench/microcode_seq.sv ***
// Sequencer model: drives one microword per machine cycle into the datapath.
// Assumes the bench clock; issue changes its fields 1 ns after a rising edge, the bench sets shiftMode 2 ns after.
`timescale 1ns/100ps
`default_nettype none
module microcode_seq (
	input wire logic clk,
	input wire logic [3:0] condFlags,
	output var exec_pkg::op_t opSel,
	output logic [4:0] rdAddrA,
	output logic [4:0] rdAddrB,
	output logic microMode,
	output logic wideRead,
	output logic useImm,
	output logic [15:0] immData,
	output logic wrEn,
	output logic [4:0] wrAddr,
	output var exec_pkg::shift_t shiftMode,
	output logic [4:0] shiftAmt,
	output logic [1:0] macLoadGroup,
	output logic branchTaken
);
////////////////////////////////////////////////////////////////////////////////
// Conditional step follows the zero flag
assign branchTaken = condFlags[1];

initial begin
	opSel = exec_pkg::OP_NONE;
	rdAddrA = 5'h00;
	rdAddrB = 5'h01;
	microMode = 1'b1;
	wideRead = 1'b0;
	useImm = 1'b1;
	immData = 16'h0000;
	wrEn = 1'b0;
	wrAddr = 5'h00;
	shiftMode = exec_pkg::SH_LOGICAL;
	shiftAmt = 5'h04;
	macLoadGroup = 2'h0;
end

////////////////////////////////////////////////////////////////////////////////
// Held for a whole cycle so the edge never races the change
task automatic issue(input exec_pkg::op_t op, input logic [4:0] a, input logic [15:0] imm,
		input logic we, input logic [4:0] wa);
	@(posedge clk);
	#1;
	opSel = op;
	rdAddrA = a;
	immData = imm;
	wrEn = we;
	wrAddr = wa;
endtask : issue

endmodule : microcode_seq
`default_nettype wire

// *** testbench/tb_cpu_execution_datapath.sv ***
// Self-checking bench for the execution datapath.
// Assumes the sequencer model drives every microword input.
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_execution_datapath;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	exec_pkg::op_t opSel;
	exec_pkg::shift_t shiftMode;
	logic [4:0] rdAddrA, rdAddrB, wrAddr, shiftAmt;
	logic microMode, wideRead, useImm, wrEn, privilegedLegal, macDone, accessFault, branchTaken;
	logic [1:0] macLoadGroup;
	logic [15:0] immData, portA, portB, portC, aluResult, statusWord;
	logic [3:0] condFlags, pageSetSelect, privilegeKey;
	logic [31:0] macAcc;
	int num_errors = 0;
	int checks = 0;
	typedef struct {exec_pkg::op_t op; exec_pkg::shift_t sm; logic [15:0] imm;
		logic [15:0] res; logic [3:0] fl;} row_t;
	// Operand A is 7fff; flags {C,P,Z,N}; logic and shift keep carry
	row_t rows [13] = '{
		'{exec_pkg::OP_ADD, exec_pkg::SH_LOGICAL, 16'h0001, 16'h8000, 4'h1},
		'{exec_pkg::OP_SUB, exec_pkg::SH_LOGICAL, 16'h7fff, 16'h0000, 4'ha},
		'{exec_pkg::OP_AND, exec_pkg::SH_LOGICAL, 16'h00f0, 16'h00f0, 4'hc},
		'{exec_pkg::OP_OR, exec_pkg::SH_LOGICAL, 16'h8000, 16'hffff, 4'h9},
		'{exec_pkg::OP_XOR, exec_pkg::SH_LOGICAL, 16'h7fff, 16'h0000, 4'ha},
		'{exec_pkg::OP_NOT, exec_pkg::SH_LOGICAL, 16'h0000, 16'h8000, 4'h9},
		'{exec_pkg::OP_ADD, exec_pkg::SH_LOGICAL, 16'h8001, 16'h0000, 4'ha},
		'{exec_pkg::OP_ADC, exec_pkg::SH_LOGICAL, 16'h0000, 16'h8000, 4'h1},
		'{exec_pkg::OP_SBB, exec_pkg::SH_LOGICAL, 16'h0000, 16'h7ffe, 4'hc},
		'{exec_pkg::OP_SHIFT, exec_pkg::SH_LOGICAL, 16'h0000, 16'h07ff, 4'hc},
		'{exec_pkg::OP_SHIFT, exec_pkg::SH_ARITH, 16'h0000, 16'h07ff, 4'hc},
		'{exec_pkg::OP_SHIFT, exec_pkg::SH_ROTATE, 16'h0000, 16'hf7ff, 4'h9},
		'{exec_pkg::OP_SHIFT, exec_pkg::SH_FUNNEL, 16'h7fff, 16'hf7ff, 4'h9}};

	always #5 clk = ~clk;

	cpu_execution_datapath i_dut (.clk(clk), .rst_n(rst_n), .opSel(opSel), .rdAddrA(rdAddrA),
		.rdAddrB(rdAddrB), .microMode(microMode), .wideRead(wideRead), .useImm(useImm),
		.immData(immData), .wrEn(wrEn), .wrAddr(wrAddr), .shiftMode(shiftMode),
		.shiftAmt(shiftAmt), .macLoadGroup(macLoadGroup), .portA(portA), .portB(portB),
		.portC(portC), .aluResult(aluResult), .statusWord(statusWord), .condFlags(condFlags),
		.pageSetSelect(pageSetSelect), .privilegeKey(privilegeKey),
		.privilegedLegal(privilegedLegal), .macAcc(macAcc), .macDone(macDone),
		.accessFault(accessFault));

	microcode_seq i_seq (.clk(clk), .condFlags(condFlags), .opSel(opSel), .rdAddrA(rdAddrA),
		.rdAddrB(rdAddrB), .microMode(microMode), .wideRead(wideRead), .useImm(useImm),
		.immData(immData), .wrEn(wrEn), .wrAddr(wrAddr), .shiftMode(shiftMode),
		.shiftAmt(shiftAmt), .macLoadGroup(macLoadGroup), .branchTaken(branchTaken));
////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude

	// Register 23 is never written, so OR with it loads a constant
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		i_seq.issue(exec_pkg::OP_OR, 5'h17, v, 1'b1, a);
	endtask : wr

	task automatic nop;
		i_seq.issue(exec_pkg::OP_NONE, 5'h01, 16'h0000, 1'b0, 5'h00);
		#1;
	endtask : nop
////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		num_errors++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		wr(5'h01, 16'h7fff);
		foreach (rows[i]) begin
			i_seq.shiftMode = rows[i].sm;
			i_seq.issue(rows[i].op, 5'h01, rows[i].imm, 1'b0, 5'h00);
			#1 check(aluResult, rows[i].res);
			nop();
			check(condFlags, rows[i].fl);
			check(statusWord[15:12], rows[i].fl);
			check(branchTaken, rows[i].fl[1]);
		end
		// Multiply 7fff by 1234 in four slices, a fifth step must be ignored
		i_seq.issue(exec_pkg::OP_MAC_CLR, 5'h01, 16'h0000, 1'b0, 5'h00);
		repeat (5) i_seq.issue(exec_pkg::OP_MAC_STEP, 5'h01, 16'h1234, 1'b0, 5'h00);
		nop();
		check(macAcc, 32'h0919_edcc);
		check(macDone, 1'b1);
		check(condFlags, 4'h9);
		wr(5'h0f, 16'haaaa);
		wr(5'h00, 16'h5555);
		wr(5'h14, 16'h1234);
		wr(5'h18, 16'hffff);
		i_seq.issue(exec_pkg::OP_NONE, 5'h14, 16'h0000, 1'b0, 5'h00);
		#1 check(portA, 16'h1234);
		i_seq.issue(exec_pkg::OP_NONE, 5'h18, 16'h0000, 1'b0, 5'h00);
		#1 check(accessFault, 1'b1);
		check(portA, 16'h5555);
		i_seq.issue(exec_pkg::OP_NONE, 5'h0f, 16'h0000, 1'b0, 5'h00);
		i_seq.microMode = 1'b0;
		i_seq.wideRead = 1'b1;
		#1 check({portA, portB, portC}, {16'haaaa, 16'h5555, 16'h7fff});
		@(posedge clk);
		#1 i_seq.microMode = 1'b1;
		i_seq.wideRead = 1'b0;
		// Start at the third group: two steps use multiplier bits 15:8 only
		i_seq.macLoadGroup = 2'h2;
		i_seq.issue(exec_pkg::OP_MAC_CLR, 5'h0f, 16'h0000, 1'b0, 5'h00);
		repeat (2) i_seq.issue(exec_pkg::OP_MAC_STEP, 5'h0f, 16'h1234, 1'b0, 5'h00);
		nop();
		check(macAcc, 32'hf9ff_f400);
		check(macDone, 1'b1);
		i_seq.issue(exec_pkg::OP_LOAD_SW, 5'h17, 16'h0007, 1'b0, 5'h00);
		nop();
		check({privilegedLegal, pageSetSelect}, 5'h17);
		i_seq.issue(exec_pkg::OP_LOAD_SW, 5'h17, 16'haf53, 1'b0, 5'h00);
		nop();
		check(statusWord, 16'ha053);
		check({privilegeKey, pageSetSelect}, 8'h53);
		check(privilegedLegal, 1'b0);
		// Reset in mid-run clears state at once, without a clock edge
		@(posedge clk);
		#1 rst_n = 1'b0;
		#1 check({statusWord, macAcc[15:0]}, 32'h0000_0000);
		check(privilegedLegal, 1'b1);
		@(posedge clk);
		#1 rst_n = 1'b1;
		// First microword after release must run on cleared registers
		i_seq.issue(exec_pkg::OP_ADD, 5'h0f, 16'h0000, 1'b0, 5'h00);
		#1 check(aluResult, 16'h0000);
		nop();
		check({portA, condFlags, macDone}, {16'h0000, 4'h2, 1'b0});
		conclude();
	end
endmodule : tb_cpu_execution_datapath
`default_nettype wire
